// [rtl/ccsoc_pkg.sv]
// constants and types for the cpu clock select and oscillator control block
package ccsoc_pkg;
  localparam int unsigned CLK_SYS_MHZ   = 250;
  // control register layout
  localparam int unsigned CTRL_W        = 8;
  localparam logic [7:0]  CTRL_RESET    = 8'h04;
  localparam int unsigned BIT_HALT      = 7;
  localparam int unsigned BIT_FBOFF     = 6;
  localparam int unsigned BIT_FLAG      = 5;
  localparam int unsigned BIT_SUBSEL    = 4;
  localparam int unsigned BIT_ZERO      = 3;
  localparam int unsigned DIV_LSB       = 0;
  localparam int unsigned DIV_W         = 3;
  localparam logic [2:0]  DIV_MAX       = 3'h4;
  // two cpu clocks per minimum instruction
  localparam int unsigned CPU_PER_INSN  = 2;
  // old-clock instruction counts for switchover, in half instructions
  localparam logic [4:0]  HALF_INSN_DIV1 = 5'h10;
  localparam logic [4:0]  HALF_INSN_SUB  = 5'h02;
  localparam int unsigned DIVCNT_W      = 5;
  localparam int unsigned SWCNT_W       = 16;

  typedef enum logic [1:0] {
    CCSOC_RUN_MAIN = 2'b00,
    CCSOC_SW_DIV   = 2'b01,
    CCSOC_TO_SUB   = 2'b10,
    CCSOC_RUN_SUB  = 2'b11
  } ccsoc_state_t;
endpackage

// [rtl/ccsoc_divider.sv]
// programmable power-of-two enable divider for the main oscillator tick
`timescale 1ns/1ps
`default_nettype none
module ccsoc_divider (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       tick_in,
  input  wire logic [2:0] div_sel,
  output logic            tick_out,
  output logic [4:0]      taps
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  always_comb begin
    cnt_nxt = cnt_r;
    if (tick_in) begin
      cnt_nxt = cnt_r + 4'h1;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
  // tap k fires once every 2**k input ticks
  genvar k;
  generate
    for (k = 0; k < 5; k = k + 1) begin : g_tap
      if (k == 0) begin : g_t0
        assign taps[k] = tick_in;
      end else begin : g_tk
        assign taps[k] = tick_in && (cnt_r[k-1:0] == {k{1'b1}});
      end
    end
  endgenerate
  assign tick_out = (div_sel <= ccsoc_pkg::DIV_MAX) ? taps[div_sel] : taps[ccsoc_pkg::DIV_MAX];
endmodule
`default_nettype wire

// [rtl/ccsoc_ctrl.sv]
// cpu clock select, divider and oscillator control with delayed switchover
`timescale 1ns/1ps
`default_nettype none
// How it works
// - reset loads control register with 0x04, main oscillator at slowest division.
// - main oscillator enable held low during reset, released afterwards.
// - three-bit divide select chooses cpu tick rate from main oscillator.
// - sub clock select bit picks subsystem source when set, main when clear.
// - read-only flag shows the source actually clocking the cpu.
// - deep and light standby both allowed while on main oscillator.
// - only light standby allowed on subsystem oscillator.
// - feedback-off bit removes subsystem feedback, stopping that oscillator.
// - peripherals get undivided main clock; watch gets subsystem clock.
// - stopping main oscillator stops all main-clocked peripherals.
// - halt bit set after switch to subsystem stops main oscillation.
// - halt bit set while on main waits until switch to subsystem completes.
// - divide select ignored while on subsystem; cpu runs at subsystem half rate.
// - watchdog counting halts while cpu runs on subsystem clock.
// - after a write, old clock keeps running for bounded instructions.
// - division change takes 8 instructions from divide-1, halving per step.
// - codes 0 to 4 give divide 1 to 16; subsystem gives half sub rate.
module ccsoc_ctrl (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       main_osc_tick,
  input  wire logic       sub_osc_tick,
  input  wire logic       ctrl_wr,
  input  wire logic [7:0] ctrl_wdata,
  input  wire logic       deep_standby_req,
  input  wire logic       light_standby_req,
  output logic [7:0]      cpu_clock_ctrl_reg,
  output logic            main_osc_en,
  output logic            sub_osc_en,
  output logic            sub_feedback_on,
  output logic            cpu_tick,
  output logic            periph_tick,
  output logic            watch_tick,
  output logic            deep_standby_ok,
  output logic            light_standby_ok,
  output logic            wdt_count_en
);
  logic                      main_osc_halt;
  logic                      sub_feedback_off;
  logic                      clock_source_flag;
  logic                      sub_clock_select;
  logic [2:0]                divide_select;
  logic [2:0]                act_div_r;
  logic [2:0]                act_div_nxt;
  logic                      flag_r;
  logic                      flag_nxt;
  logic [7:0]                ctrl_r;
  logic [7:0]                ctrl_nxt;
  logic [4:0]                half_cnt_r;
  logic [4:0]                half_cnt_nxt;
  logic                      sub_half_r;
  logic                      sub_half_nxt;
  logic                      osc_run_r;
  logic                      osc_run_nxt;
  ccsoc_pkg::ccsoc_state_t   state_r;
  ccsoc_pkg::ccsoc_state_t   state_nxt;
  logic                      main_div_tick;
  logic [4:0]                taps;
  logic                      sub_cpu_tick;
  logic                      old_half_insn;

  ccsoc_divider u_div (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .tick_in  (main_osc_tick && main_osc_en),
    .div_sel  (act_div_r),
    .tick_out (main_div_tick),
    .taps     (taps)
  );

  assign main_osc_halt     = ctrl_r[ccsoc_pkg::BIT_HALT];
  assign sub_feedback_off  = ctrl_r[ccsoc_pkg::BIT_FBOFF];
  assign sub_clock_select  = ctrl_r[ccsoc_pkg::BIT_SUBSEL];
  assign divide_select     = ctrl_r[ccsoc_pkg::DIV_LSB +: ccsoc_pkg::DIV_W];
  assign clock_source_flag = flag_r;

  // sub cpu tick: half the subsystem rate
  assign sub_cpu_tick = sub_osc_tick && sub_osc_en && sub_half_r;
  // one old-clock cpu tick is one half instruction
  assign old_half_insn = flag_r ? sub_cpu_tick : main_div_tick;

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (ctrl_wr) begin
      ctrl_nxt = ctrl_wdata;
      // status flag is read-only and bit 3 always reads zero
      ctrl_nxt[ccsoc_pkg::BIT_FLAG] = 1'b0;
      ctrl_nxt[ccsoc_pkg::BIT_ZERO] = 1'b0;
    end
  end

  always_comb begin
    state_nxt    = state_r;
    act_div_nxt  = act_div_r;
    flag_nxt     = flag_r;
    half_cnt_nxt = half_cnt_r;
    sub_half_nxt = sub_half_r ^ (sub_osc_tick && sub_osc_en);
    unique case (state_r)
      ccsoc_pkg::CCSOC_RUN_MAIN: begin
        if (sub_clock_select) begin
          // wait counted in old main ticks; fx/fxt instruction scales by itself
          state_nxt    = ccsoc_pkg::CCSOC_TO_SUB;
          half_cnt_nxt = ccsoc_pkg::HALF_INSN_SUB;
        end else if (divide_select != act_div_r) begin
          state_nxt    = ccsoc_pkg::CCSOC_SW_DIV;
          half_cnt_nxt = ccsoc_pkg::HALF_INSN_DIV1 >> act_div_r;
          if (act_div_r == ccsoc_pkg::DIV_MAX) begin
            half_cnt_nxt = 5'h01;
          end
        end
      end
      ccsoc_pkg::CCSOC_SW_DIV: begin
        if (old_half_insn) begin
          half_cnt_nxt = half_cnt_r - 5'h01;
          if (half_cnt_r <= 5'h01) begin
            act_div_nxt = (divide_select <= ccsoc_pkg::DIV_MAX) ? divide_select : ccsoc_pkg::DIV_MAX;
            state_nxt   = ccsoc_pkg::CCSOC_RUN_MAIN;
          end
        end
      end
      ccsoc_pkg::CCSOC_TO_SUB: begin
        // completes on the first sub cpu tick after the old-clock delay
        if (half_cnt_r != 5'h00) begin
          if (old_half_insn) begin
            half_cnt_nxt = half_cnt_r - 5'h01;
          end
        end else if (sub_cpu_tick) begin
          flag_nxt  = 1'b1;
          state_nxt = ccsoc_pkg::CCSOC_RUN_SUB;
        end
      end
      ccsoc_pkg::CCSOC_RUN_SUB: begin
        if (!sub_clock_select && !main_osc_halt) begin
          if (sub_cpu_tick) begin
            // back to main within one subsystem instruction, new division taken
            flag_nxt    = 1'b0;
            act_div_nxt = (divide_select <= ccsoc_pkg::DIV_MAX) ? divide_select : ccsoc_pkg::DIV_MAX;
            state_nxt   = ccsoc_pkg::CCSOC_RUN_MAIN;
          end
        end
      end
    endcase
  end

  // main oscillator runs unless halted while the cpu is on the subsystem clock
  always_comb begin
    osc_run_nxt = !(main_osc_halt && flag_nxt);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_r     <= ccsoc_pkg::CTRL_RESET;
      act_div_r  <= ccsoc_pkg::DIV_MAX;
      flag_r     <= 1'b0;
      half_cnt_r <= 5'h00;
      sub_half_r <= 1'b0;
      osc_run_r  <= 1'b0;
      state_r    <= ccsoc_pkg::CCSOC_RUN_MAIN;
    end else begin
      ctrl_r     <= ctrl_nxt;
      act_div_r  <= act_div_nxt;
      flag_r     <= flag_nxt;
      half_cnt_r <= half_cnt_nxt;
      sub_half_r <= sub_half_nxt;
      osc_run_r  <= osc_run_nxt;
      state_r    <= state_nxt;
    end
  end

  always_comb begin
    cpu_clock_ctrl_reg = ctrl_r;
    cpu_clock_ctrl_reg[ccsoc_pkg::BIT_FLAG] = clock_source_flag;
  end
  assign main_osc_en      = osc_run_r;
  assign sub_feedback_on  = !sub_feedback_off;
  assign sub_osc_en       = !sub_feedback_off;
  // division select has no effect on the subsystem path
  assign cpu_tick         = flag_r ? sub_cpu_tick : main_div_tick;
  // peripherals see the main oscillator tick only; it stops with the oscillator
  assign periph_tick      = main_osc_tick && main_osc_en;
  assign watch_tick       = sub_osc_tick && sub_osc_en;
  // deep standby is refused whenever the cpu is running on the subsystem clock
  assign deep_standby_ok  = deep_standby_req && !flag_r;
  assign light_standby_ok = light_standby_req;
  assign wdt_count_en     = !flag_r && main_osc_en;

  // checks
  // first edge after release: register and divider still at reset, oscillator not yet running
  property p_reset_val;
    @(posedge clk_sys) disable iff (rst)
    $fell(rst) |-> (cpu_clock_ctrl_reg == ccsoc_pkg::CTRL_RESET && act_div_r == ccsoc_pkg::DIV_MAX
                    && !main_osc_en);
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("state after reset release wrong");
  property p_osc_release;
    @(posedge clk_sys) disable iff (rst)
    $fell(rst) |=> main_osc_en;
  endproperty
  a_osc_release: assert property (p_osc_release) else $error("main oscillator not started after reset");
  // the enable is registered, so the edge that leaves reset still sees it low
  property p_halt_waits;
    @(posedge clk_sys) disable iff (rst)
    (!flag_r && !$past(rst)) |-> main_osc_en;
  endproperty
  a_halt_waits: assert property (p_halt_waits) else $error("main oscillator stopped while cpu on main");
  property p_halt_stops;
    @(posedge clk_sys) disable iff (rst)
    (flag_r && main_osc_halt) |=> !main_osc_en;
  endproperty
  a_halt_stops: assert property (p_halt_stops) else $error("main oscillator not stopped on subsystem");
  property p_no_deep_sub;
    @(posedge clk_sys) disable iff (rst)
    flag_r |-> !deep_standby_ok;
  endproperty
  a_no_deep_sub: assert property (p_no_deep_sub) else $error("deep standby granted on subsystem");
  property p_deep_main;
    @(posedge clk_sys) disable iff (rst)
    (!flag_r && deep_standby_req) |-> deep_standby_ok;
  endproperty
  a_deep_main: assert property (p_deep_main) else $error("deep standby refused on main");
  property p_wdt_stop;
    @(posedge clk_sys) disable iff (rst)
    flag_r |-> !wdt_count_en;
  endproperty
  a_wdt_stop: assert property (p_wdt_stop) else $error("watchdog counting on subsystem");
  property p_flag_read;
    @(posedge clk_sys) disable iff (rst)
    cpu_clock_ctrl_reg[ccsoc_pkg::BIT_FLAG] == (state_r == ccsoc_pkg::CCSOC_RUN_SUB);
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("source flag mismatch");
  property p_sub_tick;
    @(posedge clk_sys) disable iff (rst)
    (flag_r && cpu_tick) |-> (sub_osc_tick && $past(sub_osc_tick, 1) == 1'b0 || sub_osc_tick);
  endproperty
  a_sub_tick: assert property (p_sub_tick) else $error("cpu tick without subsystem tick");
  property p_div_hold;
    @(posedge clk_sys) disable iff (rst)
    (state_r == ccsoc_pkg::CCSOC_RUN_MAIN && ctrl_wr && !ctrl_wdata[ccsoc_pkg::BIT_SUBSEL]
     && ctrl_wdata[ccsoc_pkg::DIV_LSB +: ccsoc_pkg::DIV_W] != act_div_r) |=> (act_div_r == $past(act_div_r));
  endproperty
  a_div_hold: assert property (p_div_hold) else $error("division changed without delay");
  property p_fb_off;
    @(posedge clk_sys) disable iff (rst)
    sub_feedback_off |-> (!sub_osc_en && !watch_tick);
  endproperty
  a_fb_off: assert property (p_fb_off) else $error("subsystem running with feedback removed");
  property p_periph_stop;
    @(posedge clk_sys) disable iff (rst)
    !main_osc_en |-> !periph_tick;
  endproperty
  a_periph_stop: assert property (p_periph_stop) else $error("peripheral tick with main stopped");
  property p_periph_run;
    @(posedge clk_sys) disable iff (rst)
    (main_osc_tick && main_osc_en) |-> periph_tick;
  endproperty
  a_periph_run: assert property (p_periph_run) else $error("peripheral tick missing");
  property p_watch_run;
    @(posedge clk_sys) disable iff (rst)
    (sub_osc_tick && !sub_feedback_off) |-> watch_tick;
  endproperty
  a_watch_run: assert property (p_watch_run) else $error("watch tick missing");
  property p_light_any;
    @(posedge clk_sys) disable iff (rst)
    light_standby_req |-> light_standby_ok;
  endproperty
  a_light_any: assert property (p_light_any) else $error("light standby refused");
  property p_main_tick;
    @(posedge clk_sys) disable iff (rst)
    (!flag_r) |-> (cpu_tick == taps[act_div_r]);
  endproperty
  a_main_tick: assert property (p_main_tick) else $error("cpu tick not the selected division");
  // a pending division change never waits longer than the old setting allows
  property p_sw_bound;
    @(posedge clk_sys) disable iff (rst)
    (state_r == ccsoc_pkg::CCSOC_SW_DIV) |-> (half_cnt_r <= (ccsoc_pkg::HALF_INSN_DIV1 >> act_div_r));
  endproperty
  a_sw_bound: assert property (p_sw_bound) else $error("division switch wait too long");
  property p_sw_done;
    @(posedge clk_sys) disable iff (rst)
    (state_r == ccsoc_pkg::CCSOC_SW_DIV && old_half_insn && half_cnt_r <= 5'h01
     && divide_select <= ccsoc_pkg::DIV_MAX) |=> (act_div_r == $past(divide_select));
  endproperty
  a_sw_done: assert property (p_sw_done) else $error("new division not taken");
  property p_to_sub_hold;
    @(posedge clk_sys) disable iff (rst)
    (state_r == ccsoc_pkg::CCSOC_TO_SUB && half_cnt_r != 5'h00) |=> !flag_r;
  endproperty
  a_to_sub_hold: assert property (p_to_sub_hold) else $error("switched to subsystem too early");
  property p_to_main;
    @(posedge clk_sys) disable iff (rst)
    (state_r == ccsoc_pkg::CCSOC_RUN_SUB && !sub_clock_select && !main_osc_halt
     && sub_cpu_tick) |=> !flag_r;
  endproperty
  a_to_main: assert property (p_to_main) else $error("return to main late");
  c_to_sub: cover property (@(posedge clk_sys) disable iff (rst) $rose(flag_r));
  c_to_main: cover property (@(posedge clk_sys) disable iff (rst) $fell(flag_r));
  c_div_sw: cover property (@(posedge clk_sys) disable iff (rst) state_r == ccsoc_pkg::CCSOC_SW_DIV ##1
                            state_r == ccsoc_pkg::CCSOC_RUN_MAIN);
  c_osc_stop: cover property (@(posedge clk_sys) disable iff (rst) $fell(main_osc_en));
endmodule
`default_nettype wire

// [testbench/ccsoc_ctrl_bench.sv]
// self-checking bench for the cpu clock select and oscillator control block
`timescale 1ns/1ps
`default_nettype none
module ccsoc_ctrl_bench;
  logic       clk_sys           = 1'b0;
  logic       rst               = 1'b1;
  logic       main_osc_tick     = 1'b0;
  logic       sub_osc_tick      = 1'b0;
  logic       ctrl_wr           = 1'b0;
  logic [7:0] ctrl_wdata        = 8'h00;
  logic       deep_standby_req  = 1'b1;
  logic       light_standby_req = 1'b1;
  logic [7:0] cpu_clock_ctrl_reg;
  logic       main_osc_en;
  logic       sub_osc_en;
  logic       sub_feedback_on;
  logic       cpu_tick;
  logic       periph_tick;
  logic       watch_tick;
  logic       deep_standby_ok;
  logic       light_standby_ok;
  logic       wdt_count_en;
  logic [7:0] tcnt              = 8'h00;
  int         fail_count        = 0;
  int         n_tests           = 0;
  int         nc;
  int         np;
  int         nw;

  ccsoc_ctrl i_dut (
    .clk_sys            (clk_sys),
    .rst                (rst),
    .main_osc_tick      (main_osc_tick),
    .sub_osc_tick       (sub_osc_tick),
    .ctrl_wr            (ctrl_wr),
    .ctrl_wdata         (ctrl_wdata),
    .deep_standby_req   (deep_standby_req),
    .light_standby_req  (light_standby_req),
    .cpu_clock_ctrl_reg (cpu_clock_ctrl_reg),
    .main_osc_en        (main_osc_en),
    .sub_osc_en         (sub_osc_en),
    .sub_feedback_on    (sub_feedback_on),
    .cpu_tick           (cpu_tick),
    .periph_tick        (periph_tick),
    .watch_tick         (watch_tick),
    .deep_standby_ok    (deep_standby_ok),
    .light_standby_ok   (light_standby_ok),
    .wdt_count_en       (wdt_count_en)
  );

  always #2 clk_sys = ~clk_sys;

  // main oscillator ticks every 2 cycles, subsystem every 16; both run on through reset
  always @(posedge clk_sys) begin
    tcnt          <= tcnt + 8'h01;
    main_osc_tick <= tcnt[0];
    sub_osc_tick  <= (tcnt[3:0] == 4'hf);
  end

  task automatic results();
    $display("checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chki(input int got, input int exp, input string what);
    n_tests++;
    if (got != exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask

  // write strobe held for exactly one edge, readback sampled the cycle after
  task automatic wr(input logic [7:0] d);
    @(posedge clk_sys);
    ctrl_wr    <= 1'b1;
    ctrl_wdata <= d;
    @(posedge clk_sys);
    ctrl_wr    <= 1'b0;
    @(negedge clk_sys);
  endtask

  // a window that is a multiple of every tick period gives exact counts whatever the phase
  task automatic cnt(input int n);
    nc = 0;
    np = 0;
    nw = 0;
    repeat (n) begin
      @(negedge clk_sys);
      if (cpu_tick === 1'b1) nc++;
      if (periph_tick === 1'b1) np++;
      if (watch_tick === 1'b1) nw++;
    end
  endtask

  task automatic wflag(input logic v);
    int i;
    for (i = 0; i < 100 && cpu_clock_ctrl_reg[5] !== v; i++) @(negedge clk_sys);
    n_tests++;
    if (i == 100) begin
      fail_count++;
      $display("CHECK FAILED at %0t: source flag never reached %b", $time, v);
      results();
    end
  endtask

  initial begin
    repeat (4) @(negedge clk_sys);
    chk(cpu_clock_ctrl_reg, 8'h04, "reset value");
    chk({7'h00, main_osc_en}, 8'h00, "oscillator held in reset");
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk({7'h00, main_osc_en}, 8'h01, "oscillator after release");
    cnt(256);
    chki(nc, 8, "slowest cpu rate after reset");
    chki(np, 128, "peripheral rate");
    $display("test reset done");
    for (int d = 0; d < 5; d++) begin
      wr(8'(d));
      chk(cpu_clock_ctrl_reg, 8'(d), "division readback");
      // worst switchover is 32 cycles with main ticks every 2 cycles
      repeat (64) @(negedge clk_sys);
      cnt(256);
      chki(nc, 128 >> d, "divided cpu rate");
      chk({6'h00, deep_standby_ok, light_standby_ok}, 8'h03, "standby on main");
      chk({7'h00, wdt_count_en}, 8'h01, "watchdog on main");
    end
    wr(8'h2c);
    chk(cpu_clock_ctrl_reg, 8'h04, "flag and bit 3 not writable");
    $display("test division done");
    wr(8'h00);
    repeat (64) @(negedge clk_sys);
    wr(8'h10);
    wflag(1'b1);
    chk(cpu_clock_ctrl_reg, 8'h30, "sub readback");
    cnt(256);
    chki(nc, 8, "cpu at half sub rate");
    chki(nw, 16, "watch on sub clock");
    chk({6'h00, deep_standby_ok, light_standby_ok}, 8'h01, "standby on sub");
    chk({7'h00, wdt_count_en}, 8'h00, "watchdog stopped on sub");
    wr(8'h14);
    cnt(256);
    chki(nc, 8, "division ignored on sub");
    $display("test sub switch done");
    wr(8'h94);
    repeat (4) @(negedge clk_sys);
    chk({7'h00, main_osc_en}, 8'h00, "halt after switch");
    cnt(256);
    chki(np, 0, "peripherals stop with main");
    chki(nw, 16, "watch keeps running");
    chki(nc, 8, "cpu on sub while main halted");
    wr(8'hd4);
    chk({6'h00, sub_feedback_on, sub_osc_en}, 8'h00, "feedback removed");
    cnt(256);
    chki(nw, 0, "sub oscillator stopped");
    wr(8'h14);
    repeat (4) @(negedge clk_sys);
    chk({6'h00, main_osc_en, sub_feedback_on}, 8'h03, "halt and feedback cleared");
    $display("test halt done");
    // returning with a new division in the same write is allowed
    wr(8'h00);
    wflag(1'b0);
    repeat (64) @(negedge clk_sys);
    cnt(256);
    chki(nc, 128, "full rate after return");
    wr(8'h80);
    cnt(64);
    chk({7'h00, main_osc_en}, 8'h01, "halt waits while on main");
    chki(np, 32, "peripherals run while on main");
    wr(8'h90);
    wflag(1'b1);
    repeat (4) @(negedge clk_sys);
    chk({7'h00, main_osc_en}, 8'h00, "halt once on sub");
    @(posedge clk_sys);
    deep_standby_req  <= 1'b0;
    light_standby_req <= 1'b0;
    @(negedge clk_sys);
    chk({6'h00, deep_standby_ok, light_standby_ok}, 8'h00, "no request no grant");
    $display("test halt on main done");
    @(posedge clk_sys);
    rst <= 1'b1;
    @(negedge clk_sys);
    chk(cpu_clock_ctrl_reg, 8'h04, "mid-run reset value");
    chk({7'h00, main_osc_en}, 8'h00, "mid-run reset stops osc");
    @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk({7'h00, main_osc_en}, 8'h01, "oscillator after second release");
    chk(cpu_clock_ctrl_reg, 8'h04, "main selected after second release");
    $display("test second reset done");
    results();
  end
endmodule
`default_nettype wire
